/* dpc_map.vh */
// constants shared by the ddr2 pin-control block: command codes, field positions, states
`ifndef DPC_MAP_VH
`define DPC_MAP_VH

// ****************************************************************
// command codes {cs_n, ras_n, cas_n, we_n}
// ****************************************************************
`define DPC_CMD_MRS 4'h0
`define DPC_CMD_REF 4'h1
`define DPC_CMD_PRE 4'h2
`define DPC_CMD_ACT 4'h3
`define DPC_CMD_WR 4'h4
`define DPC_CMD_RD 4'h5
`define DPC_CMD_NOP 4'h7

// ****************************************************************
// address and bank fields
// ****************************************************************
`define DPC_AP_BIT 10
`define DPC_COL_W 10
`define DPC_BA_MR 3'h0
`define DPC_BA_EMR1 3'h1

// ****************************************************************
// first extended mode register fields and reset values of both mode registers
// ****************************************************************
`define DPC_EMR1_RTT0_BIT 2
`define DPC_EMR1_RTT1_BIT 6
`define DPC_EMR1_DQSN_OFF_BIT 10
`define DPC_EMR1_RDQS_BIT 11
`define DPC_MR_RST 13'h0000
`define DPC_EMR1_RST 13'h0000

// ****************************************************************
// organisation codes
// ****************************************************************
`define DPC_ORG_X4 2'h0
`define DPC_ORG_X8 2'h1
`define DPC_ORG_X16 2'h2

// ****************************************************************
// power states, one-hot
// ****************************************************************
`define DPC_ST_NORMAL 4'h1
`define DPC_ST_PPD 4'h2
`define DPC_ST_APD 4'h4
`define DPC_ST_SREF 4'h8

`endif

/* dpc_cmd_dec.v */
// command decoder: turns chip select, ras, cas and we levels into one-hot command pulses
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.vh"

module dpc_cmd_dec (
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  output reg is_mrs,
  output reg is_ref,
  output reg is_pre,
  output reg is_act,
  output reg is_wr,
  output reg is_rd
);

  wire [3:0] code;

  // chip select is the top bit, so a deselected edge matches no code
  assign code = {cs_n, ras_n, cas_n, we_n};

  // one flag per command, all low for nop and deselect
  always @* begin
    is_mrs = (code == `DPC_CMD_MRS);
    is_ref = (code == `DPC_CMD_REF);
    is_pre = (code == `DPC_CMD_PRE);
    is_act = (code == `DPC_CMD_ACT);
    is_wr = (code == `DPC_CMD_WR);
    is_rd = (code == `DPC_CMD_RD);
  end

endmodule // dpc_cmd_dec
`default_nettype wire

/* dpc_buf2.v */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module dpc_buf2 #(
  parameter WIDTH = 49,
  parameter DEPTH = 2
) (
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [0:0] wr_ptr_reg;
  reg [0:0] rd_ptr_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;

  // full and empty straight from the occupancy count
  assign in_ready = (count_reg != DEPTH[1:0]);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready & ce;
  assign pop = out_valid & out_ready & ce;

  // storage entries; data needs no reset
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_ent
      always @(posedge clk_sys) begin
        if (push && (wr_ptr_reg == gi))
          mem_reg[gi] <= in_data;
      end
    end
  endgenerate

  // pointers and count
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 2'h1;
      else if (pop && !push)
        count_reg <= count_reg - 2'h1;
    end
  end

endmodule // dpc_buf2
`default_nettype wire

/* dpc_pin_ctrl.v */
// ddr2 device pin control: command capture, clock enable power states, termination, write masking
//
// How it works
// [RULE_01] address and control pins are captured on the rising clock edge
// [RULE_02] read data leaves as a pair of beats, one per clock crossing
// [RULE_03] cke high enables internal clocks, input buffers, output drivers; low disables
// [RULE_04] cke drop: precharge power-down or self refresh if idle, else active power-down
// [RULE_05] cke is sampled on the clock for power-down entry, exit and self-refresh entry
// [RULE_06] self refresh exit follows cke rising, taken through an asynchronous synchroniser
// [RULE_07] controller holds cke high for the whole of any read or write
// [RULE_08] power-down shuts every receiver except clock and cke
// [RULE_09] self refresh shuts every receiver except cke
// [RULE_10] an edge with chip select high carries no command
// [RULE_11] command code comes from ras, cas, we together with chip select
// [RULE_12] termination switches on when odt is registered high
// [RULE_13] x16: termination on all data, both strobe pairs, both masks
// [RULE_14] x4 and x8: termination on data, strobes, read strobes and mask only; x4 gets no read strobe termination here (term_rdqs is x8 only)
// [RULE_15] odt is ignored while the extended mode register disables termination
// [RULE_16] a beat with its mask high is not written to the array
// [RULE_17] mask sampled per beat on both strobe edges, one value per beat
// [RULE_18] x8: extended mode register picks write mask or read strobe for dm
// [RULE_19] bank address picks target bank and which mode register loads
// [RULE_20] precharge with a10 low closes one bank, a10 high closes all
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.vh"

module dpc_pin_ctrl (
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  input wire [1:0] org_sel,
  input wire cke,
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire [2:0] ba,
  input wire [12:0] addr,
  input wire odt,
  input wire [15:0] dq_in_rise,
  input wire [15:0] dq_in_fall,
  input wire [1:0] dm_rise,
  input wire [1:0] dm_fall,
  output reg [15:0] dq_out_rise,
  output reg [15:0] dq_out_fall,
  output wire dq_oe,
  output reg dqs_out,
  output wire dqs_oe,
  output wire dqs_n_oe,
  output wire [1:0] dm_out,
  output wire [1:0] dm_oe,
  output wire clk_int_en,
  output wire rx_en,
  output wire [3:0] pwr_state,
  output reg [7:0] bank_open_reg,
  output reg [12:0] mr_reg,
  output reg [12:0] emr1_reg,
  output reg term_dq,
  output reg term_dqs_lo,
  output reg term_dqs_hi,
  output reg term_rdqs,
  output reg term_dm_lo,
  output reg term_dm_hi,
  output reg arr_rd_req,
  output reg [2:0] arr_rd_bank,
  output reg [9:0] arr_rd_col,
  input wire arr_rd_valid,
  input wire [31:0] arr_rd_data,
  output wire arr_wr_valid,
  input wire arr_wr_ready,
  output wire [2:0] arr_wr_bank,
  output wire [9:0] arr_wr_col,
  output wire [31:0] arr_wr_data,
  output wire [3:0] arr_wr_be,
  output reg wr_overrun_reg
);

  // ****************************************************************
  // state and local signals
  // ****************************************************************
  localparam ST_NORMAL = `DPC_ST_NORMAL;
  localparam ST_PPD = `DPC_ST_PPD;
  localparam ST_APD = `DPC_ST_APD;
  localparam ST_SREF = `DPC_ST_SREF;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg cke_prev_reg;
  reg cke_s1_reg;
  reg cke_s2_reg;
  reg cke_s3_reg;
  reg rd_out_reg;
  reg wr_due_reg;
  reg [2:0] wr_bank_reg;
  reg [9:0] wr_col_reg;
  reg cap_valid_reg;
  reg [48:0] cap_data_reg;
  wire c_mrs;
  wire c_ref;
  wire c_pre;
  wire c_act;
  wire c_wr;
  wire c_rd;
  wire cmd_ok;
  wire all_idle;
  wire rtt_on;
  wire rdqs_mode;
  wire is_x16;
  wire is_x8;
  wire buf_in_ready;
  wire [3:0] be_now;
  wire [48:0] buf_out;

  assign is_x16 = (org_sel == `DPC_ORG_X16);
  assign is_x8 = (org_sel == `DPC_ORG_X8);
  assign all_idle = (bank_open_reg == 8'h00);
  assign pwr_state = state_reg;

  // ****************************************************************
  // clock enable and receiver gating
  // ****************************************************************
  // [RULE_03] internal clock follows cke
  assign clk_int_en = cke & state_reg[0];
  // [RULE_08] receivers off in both power-down states
  // [RULE_09] and off in self refresh too; cke has its own path
  assign rx_en = state_reg[0];

  // [RULE_10] decoder sees cs_n; high cs_n matches no command
  // [RULE_11] code built from all four command pins
  dpc_cmd_dec u_dec (
    .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .is_mrs(c_mrs),
    .is_ref(c_ref),
    .is_pre(c_pre),
    .is_act(c_act),
    .is_wr(c_wr),
    .is_rd(c_rd)
  );

  // [RULE_05] a command counts only with cke high on this and the last edge
  assign cmd_ok = rx_en & cke_prev_reg & cke;

  // ****************************************************************
  // cke sampling and self refresh exit synchroniser
  // ****************************************************************
  // [RULE_06] exit edge may be asynchronous, so it goes through two flops
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cke_prev_reg <= 1'b0;
      cke_s1_reg <= 1'b0;
      cke_s2_reg <= 1'b0;
      cke_s3_reg <= 1'b0;
    end else if (ce) begin
      cke_prev_reg <= cke;
      cke_s1_reg <= cke;
      cke_s2_reg <= cke_s1_reg;
      cke_s3_reg <= cke_s2_reg;
    end
  end

  // ****************************************************************
  // power state machine
  // ****************************************************************
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_NORMAL: begin
        // [RULE_04] entry choice by bank state and refresh command
        // [RULE_05] entry seen on a sampled falling cke
        if (cke_prev_reg && !cke) begin
          if (!all_idle)
            state_next = ST_APD;
          else if (c_ref)
            state_next = ST_SREF;
          else
            state_next = ST_PPD;
        end
      end
      ST_PPD: begin
        // [RULE_05] power-down exit on sampled cke high
        if (cke)
          state_next = ST_NORMAL;
      end
      ST_APD: begin
        if (cke)
          state_next = ST_NORMAL;
      end
      ST_SREF: begin
        // [RULE_06] leave on the synchronised rise; a level test sees the high left from entry
        if (cke_s2_reg && !cke_s3_reg)
          state_next = ST_NORMAL;
      end
      default: state_next = ST_NORMAL;
    endcase
  end

  // state register; power-up reset parks the part in precharge power-down
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      state_reg <= ST_PPD;
    else if (ce)
      state_reg <= state_next;
  end

  // ****************************************************************
  // bank tracking and mode registers
  // ****************************************************************
  // [RULE_01] pins count only at the rising clock edge
  // one flag per bank; activate opens, precharge closes
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bank_open_reg <= 8'h00;
      mr_reg <= `DPC_MR_RST;
      emr1_reg <= `DPC_EMR1_RST;
    end else if (ce && cmd_ok) begin
      // [RULE_19] bank address names the target bank
      if (c_act)
        bank_open_reg[ba] <= 1'b1;
      // [RULE_20] a10 picks one bank or all
      if (c_pre) begin
        if (addr[`DPC_AP_BIT])
          bank_open_reg <= 8'h00;
        else
          bank_open_reg[ba] <= 1'b0;
      end
      // [RULE_19] bank address picks the mode register to load
      if (c_mrs && (ba == `DPC_BA_MR))
        mr_reg <= addr;
      if (c_mrs && (ba == `DPC_BA_EMR1))
        emr1_reg <= addr;
    end
  end

  // ****************************************************************
  // on-die termination
  // ****************************************************************
  // [RULE_15] both rtt bits clear means termination disabled
  assign rtt_on = emr1_reg[`DPC_EMR1_RTT0_BIT] | emr1_reg[`DPC_EMR1_RTT1_BIT];
  // [RULE_18] read strobe mode exists only on x8 parts
  assign rdqs_mode = is_x8 & emr1_reg[`DPC_EMR1_RDQS_BIT];

  // odt receiver is off outside normal state, so termination drops with it
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      term_dq <= 1'b0;
      term_dqs_lo <= 1'b0;
      term_dqs_hi <= 1'b0;
      term_rdqs <= 1'b0;
      term_dm_lo <= 1'b0;
      term_dm_hi <= 1'b0;
    end else if (ce) begin
      // [RULE_12] registered high odt turns termination on
      // [RULE_15] odt ignored when termination is disabled
      term_dq <= odt & rtt_on & rx_en;
      term_dqs_lo <= odt & rtt_on & rx_en;
      term_dm_lo <= odt & rtt_on & rx_en;
      // [RULE_13] x16 adds the upper strobe pair and upper mask
      term_dqs_hi <= odt & rtt_on & rx_en & is_x16;
      term_dm_hi <= odt & rtt_on & rx_en & is_x16;
      // [RULE_14] read strobe pins exist only on x8 parts
      term_rdqs <= odt & rtt_on & rx_en & is_x8;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // read command goes to the array with its bank and column
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      arr_rd_req <= 1'b0;
      arr_rd_bank <= 3'h0;
      arr_rd_col <= 10'h000;
    end else if (ce) begin
      arr_rd_req <= cmd_ok & c_rd;
      if (cmd_ok && c_rd) begin
        arr_rd_bank <= ba;
        arr_rd_col <= addr[`DPC_COL_W-1:0];
      end
    end
  end

  // [RULE_02] low half on the rising crossing, high half on the falling one
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dq_out_rise <= 16'h0000;
      dq_out_fall <= 16'h0000;
      rd_out_reg <= 1'b0;
      dqs_out <= 1'b0;
    end else if (ce) begin
      rd_out_reg <= arr_rd_valid & rx_en;
      dqs_out <= arr_rd_valid & rx_en;
      if (arr_rd_valid) begin
        dq_out_rise <= arr_rd_data[15:0];
        dq_out_fall <= arr_rd_data[31:16];
      end
    end
  end

  // [RULE_03] drivers only while cke holds the part awake
  assign dq_oe = rd_out_reg & cke;
  assign dqs_oe = rd_out_reg & cke;
  assign dqs_n_oe = rd_out_reg & cke & ~emr1_reg[`DPC_EMR1_DQSN_OFF_BIT];
  // [RULE_18] in read strobe mode the mask pin drives the strobe
  assign dm_out = {1'b0, dqs_out};
  assign dm_oe = {1'b0, rd_out_reg & cke & rdqs_mode};

  // ****************************************************************
  // write path
  // ****************************************************************
  // [RULE_16] high mask blocks its byte
  // [RULE_17] one mask bit per lane per beat
  // [RULE_18] read strobe mode turns masking off
  assign be_now[0] = ~dm_rise[0] | rdqs_mode;
  assign be_now[1] = is_x16 & ~dm_rise[1];
  assign be_now[2] = ~dm_fall[0] | rdqs_mode;
  assign be_now[3] = is_x16 & ~dm_fall[1];

  // data beats follow the write command by one edge; a full stage with a full buffer means lost beats
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_due_reg <= 1'b0;
      wr_bank_reg <= 3'h0;
      wr_col_reg <= 10'h000;
      cap_valid_reg <= 1'b0;
      cap_data_reg <= 49'h0;
      wr_overrun_reg <= 1'b0;
    end else if (ce) begin
      wr_due_reg <= cmd_ok & c_wr;
      if (cmd_ok && c_wr) begin
        wr_bank_reg <= ba;
        wr_col_reg <= addr[`DPC_COL_W-1:0];
      end
      if (wr_due_reg && (!cap_valid_reg || buf_in_ready)) begin
        cap_valid_reg <= 1'b1;
        cap_data_reg <= {wr_bank_reg, wr_col_reg, dq_in_fall, dq_in_rise, be_now};
      end else if (buf_in_ready) begin
        cap_valid_reg <= 1'b0;
      end
      // sticky; nothing clears it short of reset
      if (wr_due_reg && cap_valid_reg && !buf_in_ready)
        wr_overrun_reg <= 1'b1;
    end
  end

  // buffer absorbs short array stalls so beats are not dropped
  dpc_buf2 #(
    .WIDTH(49),
    .DEPTH(2)
  ) u_buf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(cap_valid_reg),
    .in_ready(buf_in_ready),
    .in_data(cap_data_reg),
    .out_valid(arr_wr_valid),
    .out_ready(arr_wr_ready),
    .out_data(buf_out)
  );

  assign arr_wr_bank = buf_out[48:46];
  assign arr_wr_col = buf_out[45:36];
  assign arr_wr_data = buf_out[35:4];
  assign arr_wr_be = buf_out[3:0];

endmodule // dpc_pin_ctrl
`default_nettype wire

/* dpc_pin_ctrl_sva.sv */
// checker for the ddr2 pin-control block
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.vh"
module dpc_pin_ctrl_sva (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [12:0] addr,
  input wire logic odt,
  input wire logic [1:0] org_sel,
  input wire logic [3:0] pwr_state,
  input wire logic clk_int_en,
  input wire logic rx_en,
  input wire logic [7:0] bank_open_reg,
  input wire logic [12:0] emr1_reg,
  input wire logic term_dq,
  input wire logic term_dm_hi,
  input wire logic arr_rd_req,
  input wire logic [2:0] arr_rd_bank,
  input wire logic [9:0] arr_rd_col,
  input wire logic arr_wr_valid,
  input wire logic arr_wr_ready,
  input wire logic [31:0] arr_wr_data
);
  // ****************
  // helpers
  // ****************
  logic cke_q_reg;
  wire normal = pwr_state == `DPC_ST_NORMAL;
  wire taken = ce && cke && cke_q_reg && !cs_n && normal;
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire [9:0] col = addr[9:0];
  wire rtt_on = emr1_reg[`DPC_EMR1_RTT0_BIT] || emr1_reg[`DPC_EMR1_RTT1_BIT];
  // previous cke tells a command edge from a wake-up edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) cke_q_reg <= 1'b0;
    else cke_q_reg <= cke;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_rd_cmd;
    taken && cmd == `DPC_CMD_RD;
  endsequence
  sequence s_sref_wake;
    pwr_state == `DPC_ST_SREF ##0 $rose(cke);
  endsequence
  // ****************
  // properties
  // ****************
  a_cs_masks_cmd: assert property (ce && cs_n |=> !arr_rd_req && $stable(bank_open_reg))
    else $error("command taken with chip select high");
  a_rd_request: assert property (s_rd_cmd |=> arr_rd_req && arr_rd_bank == $past(ba) && arr_rd_col == $past(col))
    else $error("read request wrong");
  a_act_opens: assert property (taken && cmd == `DPC_CMD_ACT |=> bank_open_reg[$past(ba)])
    else $error("activate left bank closed");
  a_pre_all: assert property (taken && cmd == `DPC_CMD_PRE && addr[`DPC_AP_BIT] |=> bank_open_reg == 8'h00)
    else $error("precharge all left a bank open");
  a_apd_entry: assert property (normal && ce && cke_q_reg && !cke && |bank_open_reg |=> pwr_state == `DPC_ST_APD)
    else $error("active power-down not entered");
  a_clk_gate: assert property (clk_int_en == (cke && normal))
    else $error("internal clock enable wrong");
  a_rx_off: assert property (!normal |-> !rx_en)
    else $error("receivers on outside normal state");
  a_sref_exit: assert property (s_sref_wake |-> ##[1:4] normal)
    else $error("self refresh not left after cke rise");
  a_odt_on: assert property ((ce && odt && rtt_on && normal) [*2] |-> term_dq && term_dm_hi == (org_sel == `DPC_ORG_X16))
    else $error("termination not applied");
  a_odt_off: assert property (!rtt_on [*2] |-> !term_dq)
    else $error("termination on while disabled");
  a_wr_hold: assert property (arr_wr_valid && !arr_wr_ready |=> arr_wr_valid && $stable(arr_wr_data))
    else $error("write word dropped while stalled");
endmodule // dpc_pin_ctrl_sva
bind dpc_pin_ctrl dpc_pin_ctrl_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .cke(cke), .cs_n(cs_n),
  .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .org_sel(org_sel),
  .pwr_state(pwr_state), .clk_int_en(clk_int_en), .rx_en(rx_en), .bank_open_reg(bank_open_reg),
  .emr1_reg(emr1_reg), .term_dq(term_dq), .term_dm_hi(term_dm_hi), .arr_rd_req(arr_rd_req),
  .arr_rd_bank(arr_rd_bank), .arr_rd_col(arr_rd_col), .arr_wr_valid(arr_wr_valid),
  .arr_wr_ready(arr_wr_ready), .arr_wr_data(arr_wr_data));
`default_nettype wire

/* dpc_ctl_model.sv */
// controller-side model that drives the ddr2 pins of the block
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.vh"
module dpc_ctl_model (
  input wire logic clk_sys,
  output var logic cke,
  output var logic cs_n,
  output var logic ras_n,
  output var logic cas_n,
  output var logic we_n,
  output var logic [2:0] ba,
  output var logic [12:0] addr,
  output var logic odt,
  output var logic [15:0] dq_in_rise,
  output var logic [15:0] dq_in_fall,
  output var logic [1:0] dm_rise,
  output var logic [1:0] dm_fall
);
  // ****************
  // pin drivers
  // ****************
  initial begin
    cke = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    {ba, addr, odt} = 17'h0;
    {dm_fall, dm_rise, dq_in_fall, dq_in_rise} = 36'h0;
  end
  // cke moves just after an edge
  task automatic set_cke(input logic v);
    cke = v;
    @(posedge clk_sys);
    #1;
  endtask
  // wake from self refresh off the clock grid
  task automatic wake;
    #37;
    cke = 1'b1;
  endtask
  // one command for one edge; pins keep it until the next call
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
    {cs_n, ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
    @(posedge clk_sys);
    #1;
  endtask
  // deselect edges; stale data is inverted so nothing leans on a held value
  task automatic idle(input int n);
    repeat (n) begin
      cmd(4'hf, 3'($urandom), 13'($urandom));
      {dm_fall, dm_rise, dq_in_fall, dq_in_rise} = ~{dm_fall, dm_rise, dq_in_fall, dq_in_rise};
    end
  endtask
  // cke stays high, one mask per beat
  task automatic wr(input logic [2:0] b, input logic [9:0] c, input logic [35:0] d);
    cmd(`DPC_CMD_WR, b, {3'h0, c});
    {dm_fall, dm_rise, dq_in_fall, dq_in_rise} = d;
    idle(1);
  endtask
endmodule // dpc_ctl_model
`default_nettype wire

/* dpc_pin_ctrl_tb_top.sv */
// self-checking testbench for the ddr2 pin-control block
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.vh"
module dpc_pin_ctrl_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic hold = 1'b0;
  logic arr_rd_valid = 1'b0;
  logic arr_wr_ready = 1'b0;
  logic [1:0] org_sel = `DPC_ORG_X16;
  logic [31:0] arr_rd_data = 32'h0;
  wire cke, cs_n, ras_n, cas_n, we_n, odt, dq_oe, dqs_out, dqs_oe, dqs_n_oe, clk_int_en, rx_en;
  wire term_dq, term_dqs_lo, term_dqs_hi, term_rdqs, term_dm_lo, term_dm_hi;
  wire arr_rd_req, arr_wr_valid, wr_overrun_reg;
  wire [1:0] dm_rise, dm_fall, dm_out, dm_oe;
  wire [2:0] ba, arr_rd_bank, arr_wr_bank;
  wire [3:0] pwr_state, arr_wr_be;
  wire [7:0] bank_open_reg;
  wire [9:0] arr_rd_col, arr_wr_col;
  wire [12:0] addr, mr_reg, emr1_reg;
  wire [15:0] dq_in_rise, dq_in_fall, dq_out_rise, dq_out_fall;
  wire [31:0] arr_wr_data;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [63:0] wq[$];
  logic [63:0] rq[$];
  dpc_pin_ctrl DUT (.*);
  dpc_ctl_model u_ctl (.*);
  // ****************
  // clock, array side, watcher
  // ****************
  always #50 clk_sys = ~clk_sys;
  // the array stalls now and then; hold stalls it fully to fill the buffer
  always @(posedge clk_sys) arr_wr_ready <= #1 !hold && $urandom_range(3) != 0;
  // every word leaving the block is matched with the oldest note
  always @(posedge clk_sys) begin
    if (arr_wr_valid === 1'b1 && arr_wr_ready === 1'b1)
      chk_word({arr_wr_bank, arr_wr_col, arr_wr_data, arr_wr_be}, wq.size() ? wq.pop_front() : 'x);
    if (dq_oe === 1'b1)
      chk_word({dqs_oe, dqs_n_oe, dm_oe, dm_out, dqs_out, dq_out_fall, dq_out_rise}, rq.size() ? rq.pop_front() : 'x);
  end
  // a hang counts as a mismatch
  always @(posedge clk_sys) if (++cyc == 4000) begin
    failures++;
    conclude();
  end
  // ****************
  // compare and report
  // ****************
  task automatic chk_state(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t state got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ****************
  // traffic
  // ****************
  // write with random data and masks; be is the inverted mask, lower lane forced on for x8, upper lane x16 only
  task automatic wr_one(input logic keep);
    logic [2:0] b;
    logic [9:0] c;
    logic [35:0] d;
    b = 3'($urandom);
    c = 10'($urandom);
    d = {4'($urandom), 32'($urandom)};
    if (keep) wq.push_back({b, c, d[31:0], (~d[35:32] | (org_sel == `DPC_ORG_X8 ? 4'h5 : 4'h0))
      & (org_sel == `DPC_ORG_X16 ? 4'hf : 4'h5)});
    u_ctl.wr(b, c, d);
    u_ctl.idle(1);
  endtask
  // read: request seen, array answers, beats leave with the strobe
  task automatic rd_one(input logic [2:0] b, input logic [9:0] c);
    logic [31:0] d;
    d = $urandom;
    u_ctl.cmd(`DPC_CMD_RD, b, {3'h0, c});
    chk_state({arr_rd_req, arr_rd_bank, arr_rd_col}, {1'b1, b, c});
    arr_rd_valid = 1'b1;
    arr_rd_data = d;
    // both strobe enables on; the mask pin carries the read strobe on x8 only
    rq.push_back({2'b11, 1'b0, org_sel == `DPC_ORG_X8, 3'b011, d});
    u_ctl.idle(1);
    arr_rd_valid = 1'b0;
    arr_rd_data = ~d;
    u_ctl.idle(2);
  endtask
  // one full pass for one organisation, starting from reset
  task automatic run(input logic [1:0] org);
    rst_n = 1'b0;
    org_sel = org;
    hold = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    chk_state(pwr_state, `DPC_ST_PPD);
    u_ctl.set_cke(1'b1);
    u_ctl.set_cke(1'b1);
    chk_state(pwr_state, `DPC_ST_NORMAL);
    u_ctl.cmd(`DPC_CMD_MRS, `DPC_BA_EMR1, 13'h0044);
    u_ctl.cmd(`DPC_CMD_MRS, `DPC_BA_MR, 13'h0a53);
    u_ctl.idle(1);
    chk_state({mr_reg, emr1_reg}, {13'h0a53, 13'h0044});
    u_ctl.odt = 1'b1;
    u_ctl.idle(2);
    chk_state({term_dq, term_dqs_lo, term_dqs_hi, term_dm_lo, term_dm_hi, term_rdqs}, org[1] ? 6'h3e : {5'h1a, org[0]});
    // termination off, read strobe mode on (x8 only)
    u_ctl.cmd(`DPC_CMD_MRS, `DPC_BA_EMR1, 13'h0800);
    u_ctl.idle(2);
    chk_state(term_dq, 1'b0);
    u_ctl.odt = 1'b0;
    for (int i = 0; i < 8; i++) u_ctl.cmd(`DPC_CMD_ACT, 3'(i), 13'($urandom));
    u_ctl.cmd(`DPC_CMD_PRE, 3'h3, 13'h0000);
    u_ctl.cmd(4'ha, 3'h0, 13'h0400);
    u_ctl.idle(1);
    chk_state(bank_open_reg, 8'hf7);
    // clock enable low: a precharge-all on the pins must leave nothing behind
    ce = 1'b0;
    repeat ($urandom_range(4, 2)) u_ctl.cmd(`DPC_CMD_PRE, 3'($urandom), 13'h0400);
    ce = 1'b1;
    chk_state({bank_open_reg, pwr_state}, {8'hf7, `DPC_ST_NORMAL});
    rd_one(3'h5, 10'($urandom));
    repeat (6) wr_one(1'b1);
    u_ctl.idle(6);
    u_ctl.set_cke(1'b0);
    chk_state({pwr_state, clk_int_en, rx_en}, {`DPC_ST_APD, 2'b00});
    u_ctl.set_cke(1'b1);
    u_ctl.set_cke(1'b1);
    chk_state(pwr_state, `DPC_ST_NORMAL);
    u_ctl.cmd(`DPC_CMD_PRE, 3'h0, 13'h0400);
    u_ctl.cke = 1'b0;
    u_ctl.cmd(`DPC_CMD_REF, 3'h0, 13'h0000);
    u_ctl.idle(1);
    chk_state({pwr_state, rx_en}, {`DPC_ST_SREF, 1'b0});
    u_ctl.wake();
    repeat (5) @(posedge clk_sys);
    #1 chk_state(pwr_state, `DPC_ST_NORMAL);
    u_ctl.set_cke(1'b0);
    chk_state(pwr_state, `DPC_ST_PPD);
    u_ctl.set_cke(1'b1);
    u_ctl.set_cke(1'b1);
    hold = 1'b1;
    for (int i = 0; i < 5; i++) wr_one(i < 3);
    chk_state(wr_overrun_reg, 1'b1);
    hold = 1'b0;
    u_ctl.idle(16);
    chk_state(wq.size(), 0);
  endtask
  // main sequence: three passes, each starting from its own reset with a new organisation
  initial begin
    void'($urandom(32'h0c22));
    run(`DPC_ORG_X16);
    run(`DPC_ORG_X8);
    run(`DPC_ORG_X4);
    conclude();
  end
endmodule // dpc_pin_ctrl_tb_top
`default_nettype wire
